// ===== rtl/lcpio_map.svh
/*
 * register offsets, reset values and field positions of the lcd-shared port
 * and the two input-only ports.
 * assumes inclusion by bare name from the design files.
 */
`ifndef LCPIO_MAP_SVH
`define LCPIO_MAP_SVH

// ********************************
// register map
// ********************************
`define LCPIO_ADDR_W        16
`define LCPIO_OFF_A_DATA    16'hffdd
`define LCPIO_OFF_A_DIR     16'hffed
`define LCPIO_OFF_B_LEVELS  16'hffde
`define LCPIO_OFF_C_LEVELS  16'hffdf

// ********************************
// reset values and fields
// ********************************
`define LCPIO_RST_A_DATA    8'hf0
`define LCPIO_RST_A_DIR     8'hf0
`define LCPIO_UPPER_ONES    4'hf
`define LCPIO_ALL_ONES      8'hff
`define LCPIO_SEG_GPIO      4'h0
`define LCPIO_UNMAPPED_RD   8'h00

// ********************************
// analog channel codes
// ********************************
`define LCPIO_CH_B_FIRST    4'h0
`define LCPIO_CH_C_FIRST    4'h8

`endif

// ===== rtl/lcpio_pkg.sv
/*
 * types shared by the port block files.
 * assumes nothing beyond a systemverilog compiler.
 */
`default_nettype none

package lcpio_pkg;
   // operating modes of the chip as seen by the pins
   typedef enum logic [2:0] {
      LCPIO_MODE_ACTIVE    = 3'b000,
      LCPIO_MODE_SUBACTIVE = 3'b001,
      LCPIO_MODE_SLEEP     = 3'b010,
      LCPIO_MODE_SUBSLEEP  = 3'b011,
      LCPIO_MODE_WATCH     = 3'b100,
      LCPIO_MODE_STANDBY   = 3'b101
   } lcpio_mode_e;
endpackage

`default_nettype wire

// ===== rtl/lcpio_sync.sv
/*
 * three-stage synchroniser with agreement filter for a bus of pin inputs.
 * assumes asynchronous inputs and one clock.
 */
`timescale 1ns/1ps
`default_nettype none

module lcpio_sync #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_b,
   // pins and filtered level
   input  wire logic [WIDTH-1:0] pin_async,
   output logic      [WIDTH-1:0] level_ff
);
   logic [WIDTH-1:0] s1_ff;
   logic [WIDTH-1:0] s2_ff;
   logic [WIDTH-1:0] s3_ff;

   // ********************************
   // per-bit stages
   // ********************************
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_bit
         // first stage read only by the second
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               s1_ff[gi]    <= 1'b0;
               s2_ff[gi]    <= 1'b0;
               s3_ff[gi]    <= 1'b0;
               level_ff[gi] <= 1'b0;
            end else begin
               s1_ff[gi] <= pin_async[gi];
               s2_ff[gi] <= s1_ff[gi];
               s3_ff[gi] <= s2_ff[gi];
               // a change counts only once two later stages agree
               if (s2_ff[gi] == s3_ff[gi]) begin
                  level_ff[gi] <= s3_ff[gi];
               end
            end
         end
      end
   endgenerate
endmodule

`default_nettype wire

// ===== rtl/lcpio_top.sv
/*
 * lcd-shared four-bit bidirectional port and two input-only ports, with
 * the cpu register slave.
 * assumes a plain strobe bus on clk, lcd commons and analog select from
 * neighbouring blocks on the same clock, and pins from outside.
 */
// Local design decision: the address-and-strobe port.
// Summary of operation
// - four-bit output latch in low bits of the port data register
// - direction 1: data read returns the latched value
// - direction 0: data read returns the sampled pin level
// - data register resets to f0
// - direction 1 drives latch onto pin, 0 turns driver off
// - direction register is write-only and reads all ones
// - direction register resets to f0, all pins inputs
// - latch and direction act only when pin is general-purpose
// - segment select zero gives gpio, else the lcd common drives
// - pins float in reset and standby, hold in sleep, subsleep and watch
// - eight-bit input-only port without drivers
// - eight-bit port read returns sampled pin levels
// - analog-selected eight-bit port pin reads zero
// - four-bit input-only port read returns sampled levels
// - analog-selected four-bit port pin reads zero
// - data at ffdd, direction at ffed
`timescale 1ns/1ps
`default_nettype none
`include "lcpio_map.svh"

module lcpio_top #(
   parameter int B_WIDTH = 8,
   parameter int C_WIDTH = 4
) (
   // clock and reset
   input  wire logic                     clk,
   input  wire logic                     rst_b,
   // register bus
   input  wire logic [`LCPIO_ADDR_W-1:0] bus_addr,
   input  wire logic [7:0]               bus_wdata,
   input  wire logic                     bus_wr,
   input  wire logic                     bus_rd,
   output logic      [7:0]               bus_rdata_ff,
   // neighbouring controls
   input  wire logic [3:0]               segment_select_field,
   input  wire logic [3:0]               analog_channel_select,
   input  wire logic                     analog_enable,
   input  wire lcpio_pkg::lcpio_mode_e   power_mode,
   input  wire logic [3:0]               lcd_common_line,
   // bidirectional pins
   input  wire logic [3:0]               bidir_pin_in,
   output logic      [3:0]               bidir_pin_out_ff,
   output logic      [3:0]               bidir_pin_oe_ff,
   // input-only pins
   input  wire logic [B_WIDTH-1:0]       port_b_pin,
   input  wire logic [C_WIDTH-1:0]       port_c_pin
);

   // ********************************
   // registers and synchronisers
   // ********************************
   logic [3:0]         port_a_data_latch_ff;
   logic [3:0]         port_a_direction_ff;
   logic [3:0]         a_level;
   logic [B_WIDTH-1:0] b_level;
   logic [C_WIDTH-1:0] c_level;
   logic [B_WIDTH-1:0] b_analog_mask;
   logic [C_WIDTH-1:0] c_analog_mask;
   logic [7:0]         nxt_rdata;
   logic [3:0]         nxt_pin_out;
   logic [3:0]         nxt_pin_oe;
   logic               gpio_sel;
   logic               hold_mode;
   logic               float_mode;

   lcpio_sync #(.WIDTH(4)) u_sync_a (
      .clk       (clk),
      .rst_b     (rst_b),
      .pin_async (bidir_pin_in),
      .level_ff  (a_level)
   );

   // input-only ports have no driver at all
   lcpio_sync #(.WIDTH(B_WIDTH)) u_sync_b (
      .clk       (clk),
      .rst_b     (rst_b),
      .pin_async (port_b_pin),
      .level_ff  (b_level)
   );

   lcpio_sync #(.WIDTH(C_WIDTH)) u_sync_c (
      .clk       (clk),
      .rst_b     (rst_b),
      .pin_async (port_c_pin),
      .level_ff  (c_level)
   );

   // ********************************
   // register writes
   // ********************************
   // latch holds only the low nibble; upper bits are constant ones
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         port_a_data_latch_ff <= 4'(`LCPIO_RST_A_DATA);
      end else if (bus_wr && bus_addr == `LCPIO_OFF_A_DATA) begin
         port_a_data_latch_ff <= bus_wdata[3:0];
      end
   end

   // direction register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         port_a_direction_ff <= 4'(`LCPIO_RST_A_DIR);
      end else if (bus_wr && bus_addr == `LCPIO_OFF_A_DIR) begin
         port_a_direction_ff <= bus_wdata[3:0];
      end
   end

   // ********************************
   // analog masks
   // ********************************
   // channel codes 0..7 land on port b, 8..11 on port c
   genvar gb;
   generate
      for (gb = 0; gb < B_WIDTH; gb++) begin : g_bmask
         assign b_analog_mask[gb] = analog_enable &&
            (analog_channel_select == (`LCPIO_CH_B_FIRST + 4'(gb)));
      end
      for (gb = 0; gb < C_WIDTH; gb++) begin : g_cmask
         assign c_analog_mask[gb] = analog_enable &&
            (analog_channel_select == (`LCPIO_CH_C_FIRST + 4'(gb)));
      end
   endgenerate

   // ********************************
   // read path
   // ********************************
   // decode order: data, direction, port b, port c, else zero
   always_comb begin
      nxt_rdata = `LCPIO_UNMAPPED_RD;
      if (bus_addr == `LCPIO_OFF_A_DATA) begin
         nxt_rdata = {`LCPIO_UPPER_ONES,
            (port_a_direction_ff & port_a_data_latch_ff) |
            (~port_a_direction_ff & a_level)};
      end else if (bus_addr == `LCPIO_OFF_A_DIR) begin
         nxt_rdata = `LCPIO_ALL_ONES;
      end else if (bus_addr == `LCPIO_OFF_B_LEVELS) begin
         nxt_rdata = 8'(b_level & ~b_analog_mask);
      end else if (bus_addr == `LCPIO_OFF_C_LEVELS) begin
         nxt_rdata = 8'(c_level & ~c_analog_mask);
      end
   end

   // read data valid only in the cycle after the strobe
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bus_rdata_ff <= 8'h00;
      end else if (bus_rd) begin
         bus_rdata_ff <= nxt_rdata;
      end else begin
         bus_rdata_ff <= 8'h00;
      end
   end

   // ********************************
   // pin drive
   // ********************************
   assign gpio_sel   = (segment_select_field == `LCPIO_SEG_GPIO);
   assign hold_mode  = (power_mode == lcpio_pkg::LCPIO_MODE_SLEEP) ||
                       (power_mode == lcpio_pkg::LCPIO_MODE_SUBSLEEP) ||
                       (power_mode == lcpio_pkg::LCPIO_MODE_WATCH);
   assign float_mode = (power_mode == lcpio_pkg::LCPIO_MODE_STANDBY);

   // lcd common overrides direction entirely when segments are enabled
   always_comb begin
      if (gpio_sel) begin
         nxt_pin_out = port_a_data_latch_ff;
         nxt_pin_oe  = port_a_direction_ff;
      end else begin
         nxt_pin_out = lcd_common_line;
         nxt_pin_oe  = 4'hf;
      end
   end

   // holding in sleep keeps the last drive even if software rewrites
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bidir_pin_out_ff <= 4'h0;
         bidir_pin_oe_ff  <= 4'h0;
      end else if (float_mode) begin
         bidir_pin_out_ff <= 4'h0;
         bidir_pin_oe_ff  <= 4'h0;
      end else if (!hold_mode) begin
         bidir_pin_out_ff <= nxt_pin_out;
         bidir_pin_oe_ff  <= nxt_pin_oe;
      end
   end

   // ********************************
   // assertions
   // ********************************
   property p_dir_read_ones;
      @(posedge clk) disable iff (!rst_b)
      (bus_rd && bus_addr == `LCPIO_OFF_A_DIR) |=> bus_rdata_ff == 8'hff;
   endproperty
   a_dir_read_ones: assert property (p_dir_read_ones)
      else $error("direction read not all ones");

   property p_data_upper_ones;
      @(posedge clk) disable iff (!rst_b)
      (bus_rd && bus_addr == `LCPIO_OFF_A_DATA) |=> bus_rdata_ff[7:4] == 4'hf;
   endproperty
   a_data_upper_ones: assert property (p_data_upper_ones)
      else $error("data upper bits not ones");

   property p_latch_readback;
      @(posedge clk) disable iff (!rst_b)
      (bus_rd && bus_addr == `LCPIO_OFF_A_DATA) |=>
         ((bus_rdata_ff[3:0] & $past(port_a_direction_ff)) ==
          ($past(port_a_data_latch_ff) & $past(port_a_direction_ff)));
   endproperty
   a_latch_readback: assert property (p_latch_readback)
      else $error("output bit read not from latch");

   property p_pin_readback;
      @(posedge clk) disable iff (!rst_b)
      (bus_rd && bus_addr == `LCPIO_OFF_A_DATA) |=>
         ((bus_rdata_ff[3:0] & ~$past(port_a_direction_ff)) ==
          ($past(a_level) & ~$past(port_a_direction_ff)));
   endproperty
   a_pin_readback: assert property (p_pin_readback)
      else $error("input bit read not from pin");

   property p_write_latch;
      @(posedge clk) disable iff (!rst_b)
      (bus_wr && bus_addr == `LCPIO_OFF_A_DATA) |=>
         port_a_data_latch_ff == $past(bus_wdata[3:0]);
   endproperty
   a_write_latch: assert property (p_write_latch)
      else $error("latch write lost");

   property p_gpio_drive;
      @(posedge clk) disable iff (!rst_b)
      (gpio_sel && power_mode == lcpio_pkg::LCPIO_MODE_ACTIVE) |=>
         bidir_pin_oe_ff == $past(port_a_direction_ff);
   endproperty
   a_gpio_drive: assert property (p_gpio_drive)
      else $error("gpio enable not from direction");

   property p_lcd_drive;
      @(posedge clk) disable iff (!rst_b)
      (!gpio_sel && power_mode == lcpio_pkg::LCPIO_MODE_ACTIVE) |=>
         (bidir_pin_oe_ff == 4'hf && bidir_pin_out_ff == $past(lcd_common_line));
   endproperty
   a_lcd_drive: assert property (p_lcd_drive)
      else $error("lcd common not driven");

   property p_standby_float;
      @(posedge clk) disable iff (!rst_b)
      float_mode |=> bidir_pin_oe_ff == 4'h0;
   endproperty
   a_standby_float: assert property (p_standby_float)
      else $error("pins driven in standby");

   property p_hold_state;
      @(posedge clk) disable iff (!rst_b)
      hold_mode |=> $stable(bidir_pin_oe_ff) && $stable(bidir_pin_out_ff);
   endproperty
   a_hold_state: assert property (p_hold_state)
      else $error("pins changed in sleep");

   property p_b_analog_zero;
      @(posedge clk) disable iff (!rst_b)
      (bus_rd && bus_addr == `LCPIO_OFF_B_LEVELS && analog_enable &&
       analog_channel_select < 4'h8) |=>
         bus_rdata_ff[$past(analog_channel_select[2:0])] == 1'b0;
   endproperty
   a_b_analog_zero: assert property (p_b_analog_zero)
      else $error("analog pin of port b not zero");

   // port c channels sit at codes 8..11, so only bits 1:0 index the pin
   property p_c_analog_zero;
      @(posedge clk) disable iff (!rst_b)
      (bus_rd && bus_addr == `LCPIO_OFF_C_LEVELS && analog_enable &&
       analog_channel_select >= 4'h8 && analog_channel_select < 4'hc) |=>
         bus_rdata_ff[$past(analog_channel_select[1:0])] == 1'b0;
   endproperty
   a_c_analog_zero: assert property (p_c_analog_zero)
      else $error("analog pin of port c not zero");

   // with the converter idle every input bit shows its filtered level
   property p_b_level_read;
      @(posedge clk) disable iff (!rst_b)
      (bus_rd && bus_addr == `LCPIO_OFF_B_LEVELS && !analog_enable) |=>
         bus_rdata_ff[B_WIDTH-1:0] == $past(b_level);
   endproperty
   a_b_level_read: assert property (p_b_level_read)
      else $error("port b read not pin levels");

   property p_c_level_read;
      @(posedge clk) disable iff (!rst_b)
      (bus_rd && bus_addr == `LCPIO_OFF_C_LEVELS && !analog_enable) |=>
         bus_rdata_ff[C_WIDTH-1:0] == $past(c_level);
   endproperty
   a_c_level_read: assert property (p_c_level_read)
      else $error("port c read not pin levels");

   c_dir_write: cover property (@(posedge clk) disable iff (!rst_b)
      bus_wr && bus_addr == `LCPIO_OFF_A_DIR);
   c_lcd_mode: cover property (@(posedge clk) disable iff (!rst_b) !gpio_sel);
   c_sleep: cover property (@(posedge clk) disable iff (!rst_b) hold_mode);
   c_standby: cover property (@(posedge clk) disable iff (!rst_b) float_mode);
endmodule

`default_nettype wire

// ===== verification/lcpio_board.sv
/*
 * board pins beside the bidirectional port: resolves each wire level from
 * the port drive and an outside source.
 * assumes the outside source yields wherever the port drives its pin.
 */
`timescale 1ns/1ps
`default_nettype none

module lcpio_board (
   // port side
   input  wire logic [3:0] pin_out,
   input  wire logic [3:0] pin_oe,
   // outside source
   input  wire logic [3:0] ext_val,
   // resolved wire level
   output logic      [3:0] pin_level
);
   // ********************************
   // wire resolution
   // ********************************
   // outside source steps back per bit, so no contention is ever modelled
   always_comb begin
      pin_level = (pin_out & pin_oe) | (ext_val & ~pin_oe);
   end
endmodule

`default_nettype wire

// ===== verification/lcpio_top_tb.sv
/*
 * self-checking bench for the lcd-shared port and the input-only ports.
 * assumes the board model beside it and the register map header.
 */
`timescale 1ns/1ps
`default_nettype none
`include "lcpio_map.svh"
`define CHK(g, x) begin compares++; if ((g) !== (x)) begin mismatches++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x); end end

module lcpio_top_tb;
   logic                   clk = 1'b0;
   logic                   rst_b = 1'b0;
   logic [15:0]            bus_addr = 16'h0000;
   logic [7:0]             bus_wdata = 8'h00;
   logic                   bus_wr = 1'b0;
   logic                   bus_rd = 1'b0;
   logic [7:0]             bus_rdata_ff;
   logic [3:0]             seg = 4'h0;
   logic [3:0]             ach = 4'h0;
   logic                   aen = 1'b0;
   lcpio_pkg::lcpio_mode_e mode = lcpio_pkg::LCPIO_MODE_ACTIVE;
   logic [3:0]             lcd_com = 4'h0;
   logic [3:0]             ext = 4'h0;
   logic [3:0]             pin_lvl;
   logic [3:0]             pout;
   logic [3:0]             poe;
   logic [7:0]             pb = 8'h00;
   logic [3:0]             pc = 4'h0;
   int                     mismatches = 0;
   int                     compares = 0;
   logic [7:0]             expq[$];
   logic                   rd_pend = 1'b0;
   logic [7:0]             got_e;
   logic [3:0]             d, m, xo, xd;
   logic [7:0]             mb;
   logic [3:0]             mc;

   // ********************************
   // clock, design and board
   // ********************************
   always #10 clk = ~clk;

   lcpio_top uut (
      .clk(clk), .rst_b(rst_b), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata_ff(bus_rdata_ff),
      .segment_select_field(seg), .analog_channel_select(ach),
      .analog_enable(aen), .power_mode(mode), .lcd_common_line(lcd_com),
      .bidir_pin_in(pin_lvl), .bidir_pin_out_ff(pout), .bidir_pin_oe_ff(poe),
      .port_b_pin(pb), .port_c_pin(pc));

   lcpio_board board (.pin_out(pout), .pin_oe(poe), .ext_val(ext), .pin_level(pin_lvl));

   // ********************************
   // read data watcher
   // ********************************
   // read data stands one cycle only, so it is taken mid-cycle
   always @(posedge clk) rd_pend <= bus_rd;
   always @(negedge clk) begin
      if (rd_pend) begin
         if (expq.size() == 0) begin
            mismatches++;
            $display("CHECK FAILED t=%0t read data with no note", $time);
         end else begin
            got_e = expq.pop_front();
            `CHK(bus_rdata_ff, got_e)
         end
      end
   end

   // ********************************
   // bus tasks and verdict
   // ********************************
   task automatic wr(input logic [15:0] a, input logic [7:0] dt);
      @(posedge clk);
      bus_addr <= a;
      bus_wdata <= dt;
      bus_wr <= 1'b1;
      @(posedge clk);
      bus_wr <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, input logic [7:0] x);
      expq.push_back(x);
      @(posedge clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clk);
      bus_rd <= 1'b0;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic give_verdict;
      if (expq.size() != 0) mismatches++;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // a hang anywhere ends the run as a failure
   initial begin
      tick(50000);
      mismatches++;
      give_verdict();
   end

   // ********************************
   // main sequence
   // ********************************
   initial begin
      void'($urandom(49240));
      tick(10);
      rst_b <= 1'b1;
      ext <= 4'h5;
      tick(6);
      `CHK(poe, 4'h0)
      rd(`LCPIO_OFF_A_DATA, 8'hf5);
      rd(`LCPIO_OFF_A_DIR, 8'hff);
      wr(`LCPIO_OFF_A_DIR, 8'h0f);
      rd(`LCPIO_OFF_A_DATA, 8'hf0);
      // random latch, direction and outside levels; upper nibbles junk
      for (int i = 0; i < 12; i++) begin
         d = 4'($urandom);
         m = 4'($urandom);
         wr(`LCPIO_OFF_A_DATA, {4'($urandom), d});
         wr(`LCPIO_OFF_A_DIR, {4'($urandom), m});
         ext <= 4'($urandom);
         tick(6);
         `CHK(poe, m)
         `CHK(pout & m, d & m)
         rd(`LCPIO_OFF_A_DATA, {4'hf, (d & m) | (ext & ~m)});
         rd(`LCPIO_OFF_A_DIR, 8'hff);
      end
      // every segment select code against a random direction
      for (int s = 0; s < 16; s++) begin
         lcd_com <= 4'($urandom);
         seg <= 4'(s);
         tick(3);
         `CHK(poe, (s == 0) ? m : 4'hf)
         `CHK(pout & poe, (s == 0) ? (d & m) : lcd_com)
      end
      seg <= 4'h0;
      wr(`LCPIO_OFF_A_DIR, 8'h0f);
      // every power mode: latch changes while the mode holds
      for (int i = 0; i < 6; i++) begin
         wr(`LCPIO_OFF_A_DATA, 8'h0a);
         tick(2);
         mode <= lcpio_pkg::lcpio_mode_e'(i);
         tick(3);
         wr(`LCPIO_OFF_A_DATA, 8'h05);
         tick(2);
         xo = (i == 5) ? 4'h0 : 4'hf;
         xd = (i == 5) ? 4'h0 : ((i >= 2) ? 4'ha : 4'h5);
         `CHK(poe, xo)
         `CHK(pout, xd)
         mode <= lcpio_pkg::LCPIO_MODE_ACTIVE;
         tick(2);
      end
      // input-only ports over every channel code, analog on and off
      for (int i = 0; i < 32; i++) begin
         pb <= 8'($urandom);
         pc <= 4'($urandom);
         ach <= 4'(i);
         aen <= i[4];
         tick(6);
         mb = (i[4] && i[3:0] < 8) ? (8'h01 << i[2:0]) : 8'h00;
         mc = (i[4] && i[3:2] == 2'b10) ? (4'h1 << i[1:0]) : 4'h0;
         wr(`LCPIO_OFF_B_LEVELS, 8'h00);
         rd(`LCPIO_OFF_B_LEVELS, pb & ~mb);
         rd(`LCPIO_OFF_C_LEVELS, {4'h0, pc & ~mc});
      end
      rd(16'hffe0, `LCPIO_UNMAPPED_RD);
      // reset in mid-run while the port drives
      @(posedge clk);
      rst_b <= 1'b0;
      tick(3);
      `CHK(poe, 4'h0)
      @(posedge clk);
      rst_b <= 1'b1;
      ext <= 4'h9;
      tick(6);
      rd(`LCPIO_OFF_A_DATA, 8'hf9);
      tick(3);
      give_verdict();
   end
endmodule

`default_nettype wire
